//--- logic/prot_cfg.svh
`ifndef PROT_CFG_SVH
`define PROT_CFG_SVH
// threshold code: 16-bit fraction of nominal voltage, 1.0 = 16'h8000
`define THR_WIDTH 16
`define THR_MAX 16'h0CCD
`define THR_DEFAULT 16'h00A4
`define VAL_WIDTH 16
`define N_STAGES 8
`define N_MODULES 4
`define N_SOURCES 16
`define SEL_WIDTH 5
`define SEL_NONE 5'h00
`define CNT_WIDTH 16
`define CNT_RESET 16'h0000
`endif

//--- logic/prot_pkg.sv
package prot_pkg;
  typedef struct packed {
    logic l1;
    logic l2;
    logic l3;
    logic gnd;
  } phase_flags_t;
  typedef struct packed {
    logic [15:0] ph_a;
    logic [15:0] ph_b;
    logic [15:0] ph_c;
    logic [15:0] resid_meas;
    logic [15:0] resid_calc;
    logic [15:0] sym_pos;
    logic [15:0] sym_neg;
    logic [15:0] sym_zero;
  } volt_set_t;
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_BLOCKED = 3'b010,
    ST_ACTIVE = 3'b100
  } prot_state_t;
endpackage

//--- logic/prot_master.sv
`include "prot_cfg.svh"
// Summary of operation
// (R1) phase voltages below phase cutoff threshold read zero on display
// (R2) residual and symmetrical component displays zeroed below own thresholds
// (R3) recording outputs carry the unmodified voltages
// (R4) master disabled suppresses every alarm and trip
// (R5) each module has a permanent enable; disabled module held off
// (R6) per-stage permanent trip block suppresses that stage's trip
// (R7) master temporary block needs permit and an assigned source
// (R8) master blocked exactly while permitted assigned source asserted
// (R9) module blocked while its permit active and its source asserted
// (R10) stage trip externally blockable only with its trip-block permit
// (R11) with permit, stage trip suppressed while selected source asserted
// (R12) block sources select digital inputs or any internal signal
// (R13) protection active only when enabled and not blocked
// (R14) disabled or blocked master zeroes all protective outputs
// (R15) collective alarm and trip are OR of all stages
// (R16) stage and collective alarm or trip both asserted
// (R17) trip executor acts on collected trip commands
// (R18) reset command clears fault number and grid fault counters
// (R19) collective alarm and trip also per phase and earth
// (R20) two master block sources, either one blocks when permitted
// (R21) gating each cycle, collective outputs registered one cycle
module prot_master
  import prot_pkg::*;
#(
  parameter int N_STAGES = `N_STAGES,
  parameter int N_MODULES = `N_MODULES,
  parameter int N_SOURCES = `N_SOURCES
) (
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic MASTER_ENABLE_IN,
  input wire logic EXT_BLOCK_PERMIT_IN,
  input wire logic [`SEL_WIDTH-1:0] EXT_BLOCK_SOURCE_A_IN,
  input wire logic [`SEL_WIDTH-1:0] EXT_BLOCK_SOURCE_B_IN,
  input wire logic [N_SOURCES-1:0] SOURCE_SIGNALS_IN,
  input wire logic [N_MODULES-1:0] MODULE_ENABLE_IN,
  input wire logic [N_MODULES-1:0] MODULE_BLOCK_PERMIT_IN,
  input wire logic [N_MODULES*`SEL_WIDTH-1:0] MODULE_BLOCK_SOURCE_IN,
  input wire logic [N_STAGES*$clog2(N_MODULES)-1:0] STAGE_MODULE_IN,
  input wire logic [N_STAGES-1:0] TRIP_PERM_BLOCK_IN,
  input wire logic [N_STAGES-1:0] EXT_TRIP_BLOCK_PERMIT_IN,
  input wire logic [N_STAGES*`SEL_WIDTH-1:0] EXT_TRIP_BLOCK_SOURCE_IN,
  input wire phase_flags_t [N_STAGES-1:0] STAGE_ALARM_IN,
  input wire phase_flags_t [N_STAGES-1:0] STAGE_TRIP_IN,
  input wire logic STAGE_FAULT_EVENT_IN,
  input wire logic GRID_FAULT_EVENT_IN,
  input wire logic RESET_COUNTERS_IN,
  input wire volt_set_t VOLTS_IN,
  input wire logic [`THR_WIDTH-1:0] PHASE_ZERO_THRESHOLD_IN,
  input wire logic [`THR_WIDTH-1:0] RESID_MEAS_ZERO_THRESHOLD_IN,
  input wire logic [`THR_WIDTH-1:0] RESID_CALC_ZERO_THRESHOLD_IN,
  input wire logic [`THR_WIDTH-1:0] SYMCOMP_ZERO_THRESHOLD_IN,
  output logic PROT_ACTIVE_OUT,
  output logic PROT_EXT_BLOCKED_OUT,
  output logic [N_STAGES-1:0] STAGE_ALARM_OUT,
  output logic [N_STAGES-1:0] STAGE_TRIP_OUT,
  output logic [N_STAGES-1:0] STAGE_TRIP_BLOCKED_OUT,
  output phase_flags_t ALARM_PHASE_OUT,
  output phase_flags_t TRIP_PHASE_OUT,
  output logic ALARM_OUT,
  output logic TRIP_OUT,
  output volt_set_t DISPLAY_VOLTS_OUT,
  output volt_set_t RECORD_VOLTS_OUT,
  output logic [`CNT_WIDTH-1:0] FAULT_NUMBER_OUT,
  output logic [`CNT_WIDTH-1:0] GRID_FAULT_COUNT_OUT
);
  localparam int MW = (N_MODULES > 1) ? $clog2(N_MODULES) : 1;

  // ****************************************
  // elaboration checks
  // ****************************************
  // at least one stage is needed for the collective outputs to mean anything
  if (N_STAGES < 1) begin : g_bad_stages
    $error("prot_master: N_STAGES must be at least 1");
  end

  // the stage-to-module index field needs at least one bit
  if (N_MODULES < 2) begin : g_bad_modules
    $error("prot_master: N_MODULES must be at least 2");
  end

  if (N_SOURCES < 1) begin : g_bad_sources_low
    $error("prot_master: N_SOURCES must be at least 1");
  end

  // selector code 0 is reserved, so only 2**SEL_WIDTH-1 sources are reachable
  if (N_SOURCES > 31) begin : g_bad_sources_high
    $error("prot_master: N_SOURCES must not exceed 31");
  end

  // ****************************************
  // helpers
  // ****************************************
  // selector 0 means nothing assigned; code k picks source k-1
  function automatic logic pick_source(input logic [`SEL_WIDTH-1:0] sel,
                                       input logic [N_SOURCES-1:0] src);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < N_SOURCES; k++) begin
      if (sel == `SEL_WIDTH'(k + 1)) begin
        hit = src[k];
      end
    end
    return hit;
  endfunction

  // zero the display copy only; thresholds are never applied upstream
  function automatic logic [`VAL_WIDTH-1:0] cut(input logic [`VAL_WIDTH-1:0] v,
                                                input logic [`THR_WIDTH-1:0] thr);
    return (v < thr) ? `VAL_WIDTH'(0) : v;
  endfunction

  // ****************************************
  // master gating
  // ****************************************
  logic master_block;
  logic master_ok;
  prot_state_t state_next;

  // unassigned selector never blocks, so permit alone has no effect
  assign master_block = EXT_BLOCK_PERMIT_IN &
    (pick_source(EXT_BLOCK_SOURCE_A_IN, SOURCE_SIGNALS_IN) |
     pick_source(EXT_BLOCK_SOURCE_B_IN, SOURCE_SIGNALS_IN)); // [R7] [R8] [R12] [R20]
  assign master_ok = MASTER_ENABLE_IN & ~master_block; // [R13]

  always_comb begin
    if (!MASTER_ENABLE_IN) begin
      state_next = ST_OFF; // [R4]
    end else if (master_block) begin
      state_next = ST_BLOCKED; // [R8]
    end else begin
      state_next = ST_ACTIVE;
    end
  end

  // the status pair is the registered decode of the master state
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      PROT_ACTIVE_OUT <= 1'b0;
      PROT_EXT_BLOCKED_OUT <= 1'b0;
    end else begin
      case (state_next)
        ST_ACTIVE: begin
          PROT_ACTIVE_OUT <= 1'b1; // [R13]
          PROT_EXT_BLOCKED_OUT <= 1'b0;
        end
        ST_BLOCKED: begin
          PROT_ACTIVE_OUT <= 1'b0;
          PROT_EXT_BLOCKED_OUT <= 1'b1;
        end
        default: begin
          PROT_ACTIVE_OUT <= 1'b0;
          PROT_EXT_BLOCKED_OUT <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // module and stage gating
  // ****************************************
  logic [N_MODULES-1:0] module_ok;
  logic [N_STAGES-1:0] stage_ok;
  logic [N_STAGES-1:0] trip_ok;
  phase_flags_t [N_STAGES-1:0] alarm_g;
  phase_flags_t [N_STAGES-1:0] trip_g;

  always_comb begin
    for (int m = 0; m < N_MODULES; m++) begin
      module_ok[m] = MODULE_ENABLE_IN[m] & // [R5]
        ~(MODULE_BLOCK_PERMIT_IN[m] &
          pick_source(MODULE_BLOCK_SOURCE_IN[m*`SEL_WIDTH +: `SEL_WIDTH],
                      SOURCE_SIGNALS_IN)); // [R9] [R12]
    end
  end

  always_comb begin
    for (int s = 0; s < N_STAGES; s++) begin
      stage_ok[s] = master_ok &
        module_ok[MW'(STAGE_MODULE_IN[s*MW +: MW]) % N_MODULES]; // [R4] [R14]
      trip_ok[s] = ~TRIP_PERM_BLOCK_IN[s] & // [R6]
        ~(EXT_TRIP_BLOCK_PERMIT_IN[s] &
          pick_source(EXT_TRIP_BLOCK_SOURCE_IN[s*`SEL_WIDTH +: `SEL_WIDTH],
                      SOURCE_SIGNALS_IN)); // [R10] [R11]
      alarm_g[s] = stage_ok[s] ? STAGE_ALARM_IN[s] : '0;
      trip_g[s] = (stage_ok[s] & trip_ok[s]) ? STAGE_TRIP_IN[s] : '0;
    end
  end

  // ****************************************
  // collective outputs
  // ****************************************
  phase_flags_t alarm_or;
  phase_flags_t trip_or;

  always_comb begin
    alarm_or = '0;
    trip_or = '0;
    for (int s = 0; s < N_STAGES; s++) begin
      alarm_or = alarm_or | alarm_g[s]; // [R15]
      trip_or = trip_or | trip_g[s]; // [R15]
    end
  end

  // ****************************************
  // per-stage outputs
  // ****************************************
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      STAGE_ALARM_OUT <= '0;
      STAGE_TRIP_OUT <= '0;
    end else begin
      for (int s = 0; s < N_STAGES; s++) begin
        STAGE_ALARM_OUT[s] <= |alarm_g[s]; // [R16] [R21]
        STAGE_TRIP_OUT[s] <= |trip_g[s]; // [R16] [R21]
      end
    end
  end

  // shows the block even while the stage is quiet, so a setting is visible
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      STAGE_TRIP_BLOCKED_OUT <= '0;
    end else begin
      for (int s = 0; s < N_STAGES; s++) begin
        STAGE_TRIP_BLOCKED_OUT[s] <= ~trip_ok[s]; // [R6] [R11]
      end
    end
  end

  // ****************************************
  // per-phase collective outputs
  // ****************************************
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ALARM_PHASE_OUT <= '0;
      TRIP_PHASE_OUT <= '0;
    end else begin
      ALARM_PHASE_OUT <= alarm_or; // [R19]
      TRIP_PHASE_OUT <= trip_or; // [R19] [R17]
    end
  end

  // ****************************************
  // general collective outputs
  // ****************************************
  // taken from the same gated flags, so general and per-phase never disagree
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ALARM_OUT <= 1'b0;
      TRIP_OUT <= 1'b0;
    end else begin
      ALARM_OUT <= |alarm_or; // [R16] [R21]
      TRIP_OUT <= |trip_or; // [R16] [R21]
    end
  end

  // ****************************************
  // display cutoff and recording path
  // ****************************************
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      DISPLAY_VOLTS_OUT <= '0;
    end else begin
      DISPLAY_VOLTS_OUT.ph_a <= cut(VOLTS_IN.ph_a, PHASE_ZERO_THRESHOLD_IN); // [R1]
      DISPLAY_VOLTS_OUT.ph_b <= cut(VOLTS_IN.ph_b, PHASE_ZERO_THRESHOLD_IN); // [R1]
      DISPLAY_VOLTS_OUT.ph_c <= cut(VOLTS_IN.ph_c, PHASE_ZERO_THRESHOLD_IN); // [R1]
      DISPLAY_VOLTS_OUT.resid_meas <=
        cut(VOLTS_IN.resid_meas, RESID_MEAS_ZERO_THRESHOLD_IN); // [R2]
      DISPLAY_VOLTS_OUT.resid_calc <=
        cut(VOLTS_IN.resid_calc, RESID_CALC_ZERO_THRESHOLD_IN); // [R2]
      DISPLAY_VOLTS_OUT.sym_pos <= cut(VOLTS_IN.sym_pos, SYMCOMP_ZERO_THRESHOLD_IN); // [R2]
      DISPLAY_VOLTS_OUT.sym_neg <= cut(VOLTS_IN.sym_neg, SYMCOMP_ZERO_THRESHOLD_IN); // [R2]
      DISPLAY_VOLTS_OUT.sym_zero <= cut(VOLTS_IN.sym_zero, SYMCOMP_ZERO_THRESHOLD_IN); // [R2]
    end
  end

  // recorders get the raw copy; no threshold ever reaches this path
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      RECORD_VOLTS_OUT <= '0;
    end else begin
      RECORD_VOLTS_OUT <= VOLTS_IN; // [R3]
    end
  end

  // ****************************************
  // fault counters
  // ****************************************
  // reset wins over a same-cycle event; the command is an explicit clear
  // counters wrap at full scale; no saturation is applied
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      FAULT_NUMBER_OUT <= `CNT_RESET;
    end else if (RESET_COUNTERS_IN) begin
      FAULT_NUMBER_OUT <= `CNT_RESET; // [R18]
    end else if (STAGE_FAULT_EVENT_IN) begin
      FAULT_NUMBER_OUT <= FAULT_NUMBER_OUT + `CNT_WIDTH'(1);
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      GRID_FAULT_COUNT_OUT <= `CNT_RESET;
    end else if (RESET_COUNTERS_IN) begin
      GRID_FAULT_COUNT_OUT <= `CNT_RESET; // [R18]
    end else if (GRID_FAULT_EVENT_IN) begin
      GRID_FAULT_COUNT_OUT <= GRID_FAULT_COUNT_OUT + `CNT_WIDTH'(1);
    end
  end
endmodule

//--- tb/prot_properties.sv
module prot_checker
  import prot_pkg::*;
#(
  parameter int N_STAGES = 8,
  parameter int N_SOURCES = 16
) (
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic MASTER_ENABLE_IN,
  input wire logic EXT_BLOCK_PERMIT_IN,
  input wire logic [4:0] EXT_BLOCK_SOURCE_A_IN,
  input wire logic [N_SOURCES-1:0] SOURCE_SIGNALS_IN,
  input wire logic [N_STAGES-1:0] TRIP_PERM_BLOCK_IN,
  input wire logic RESET_COUNTERS_IN,
  input wire volt_set_t VOLTS_IN,
  input wire logic [15:0] PHASE_ZERO_THRESHOLD_IN,
  input wire logic PROT_ACTIVE_OUT,
  input wire logic PROT_EXT_BLOCKED_OUT,
  input wire logic [N_STAGES-1:0] STAGE_TRIP_OUT,
  input wire phase_flags_t ALARM_PHASE_OUT,
  input wire logic ALARM_OUT,
  input wire logic TRIP_OUT,
  input wire volt_set_t DISPLAY_VOLTS_OUT,
  input wire volt_set_t RECORD_VOLTS_OUT,
  input wire logic [15:0] FAULT_NUMBER_OUT,
  input wire logic [15:0] GRID_FAULT_COUNT_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // selector a decode, code 0 means unassigned
  // ****
  wire [4:0] a_sel = EXT_BLOCK_SOURCE_A_IN;
  wire a_hit = a_sel != 5'h00 && a_sel <= 5'h10 && SOURCE_SIGNALS_IN[a_sel-5'h01];
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  property p_off; !MASTER_ENABLE_IN |=> !ALARM_OUT && !TRIP_OUT && !PROT_ACTIVE_OUT; endproperty
  a_off: assert property (p_off) else $error("output while master off");
  property p_blk;
    MASTER_ENABLE_IN && EXT_BLOCK_PERMIT_IN && a_hit |=>
      PROT_EXT_BLOCKED_OUT && !PROT_ACTIVE_OUT && !TRIP_OUT;
  endproperty
  a_blk: assert property (p_blk) else $error("master not blocked");
  property p_act; MASTER_ENABLE_IN && !EXT_BLOCK_PERMIT_IN |=> PROT_ACTIVE_OUT; endproperty
  a_act: assert property (p_act) else $error("protection not active");
  property p_nop; !EXT_BLOCK_PERMIT_IN |=> !PROT_EXT_BLOCKED_OUT; endproperty
  a_nop: assert property (p_nop) else $error("blocked without permit");
  property p_perm; (STAGE_TRIP_OUT & $past(TRIP_PERM_BLOCK_IN)) == '0; endproperty
  a_perm: assert property (p_perm) else $error("blocked stage trips");
  property p_or; TRIP_OUT == (|STAGE_TRIP_OUT); endproperty
  a_or: assert property (p_or) else $error("collective trip wrong");
  property p_alm; ALARM_OUT == (|ALARM_PHASE_OUT); endproperty
  a_alm: assert property (p_alm) else $error("alarm phases wrong");
  property p_rec; 1'b1 |=> RECORD_VOLTS_OUT == $past(VOLTS_IN); endproperty
  a_rec: assert property (p_rec) else $error("record copy changed");
  property p_cut;
    VOLTS_IN.ph_a < PHASE_ZERO_THRESHOLD_IN |=> DISPLAY_VOLTS_OUT.ph_a == 16'h0000;
  endproperty
  a_cut: assert property (p_cut) else $error("small phase shown");
  property p_clr;
    RESET_COUNTERS_IN |=> FAULT_NUMBER_OUT == 16'h0000 && GRID_FAULT_COUNT_OUT == 16'h0000;
  endproperty
  a_clr: assert property (p_clr) else $error("counters not cleared");
endmodule
bind prot_master prot_checker #(.N_STAGES(N_STAGES), .N_SOURCES(N_SOURCES)) u_chk (.*);

//--- tb/stage_model.sv
module stage_model
  import prot_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire phase_flags_t [7:0] alarm_req_in,
  input wire phase_flags_t [7:0] trip_req_in,
  input wire logic trip_cmd_in,
  output phase_flags_t [7:0] alarm_out,
  output phase_flags_t [7:0] trip_out,
  output logic breaker_open_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // a tripping stage raises its own alarm as well
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      alarm_out <= '0;
      trip_out <= '0;
    end else begin
      alarm_out <= alarm_req_in | trip_req_in;
      trip_out <= trip_req_in;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) breaker_open_out <= 1'b0;
    else breaker_open_out <= trip_cmd_in;
  end
endmodule

//--- tb/tb_top.sv
module tb_top
  import prot_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // port-named signals so the design hooks up by name
  logic CLK_IN = 0, RESET_N_IN = 0, MASTER_ENABLE_IN, EXT_BLOCK_PERMIT_IN, breaker;
  logic STAGE_FAULT_EVENT_IN, GRID_FAULT_EVENT_IN, RESET_COUNTERS_IN;
  logic PROT_ACTIVE_OUT, PROT_EXT_BLOCKED_OUT, ALARM_OUT, TRIP_OUT;
  logic [4:0] EXT_BLOCK_SOURCE_A_IN, EXT_BLOCK_SOURCE_B_IN;
  logic [15:0] SOURCE_SIGNALS_IN, STAGE_MODULE_IN, PHASE_ZERO_THRESHOLD_IN;
  logic [15:0] RESID_MEAS_ZERO_THRESHOLD_IN, RESID_CALC_ZERO_THRESHOLD_IN;
  logic [15:0] SYMCOMP_ZERO_THRESHOLD_IN, FAULT_NUMBER_OUT, GRID_FAULT_COUNT_OUT;
  logic [3:0] MODULE_ENABLE_IN, MODULE_BLOCK_PERMIT_IN;
  logic [19:0] MODULE_BLOCK_SOURCE_IN;
  logic [7:0] TRIP_PERM_BLOCK_IN, EXT_TRIP_BLOCK_PERMIT_IN, STAGE_ALARM_OUT, STAGE_TRIP_OUT;
  logic [7:0] STAGE_TRIP_BLOCKED_OUT;
  logic [39:0] EXT_TRIP_BLOCK_SOURCE_IN;
  phase_flags_t [7:0] STAGE_ALARM_IN, STAGE_TRIP_IN, req_alarm, req_trip;
  phase_flags_t ALARM_PHASE_OUT, TRIP_PHASE_OUT;
  volt_set_t VOLTS_IN, DISPLAY_VOLTS_OUT, RECORD_VOLTS_OUT;
  int error_cnt = 0;
  int checked = 0;
  prot_master u_dut (.*);
  stage_model u_stage (.clk_in(CLK_IN), .rst_n_in(RESET_N_IN), .alarm_req_in(req_alarm),
    .trip_req_in(req_trip), .trip_cmd_in(TRIP_OUT), .alarm_out(STAGE_ALARM_IN),
    .trip_out(STAGE_TRIP_IN), .breaker_open_out(breaker));
  always #25 CLK_IN = ~CLK_IN;
  task finish_test;
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  // stage model adds one cycle ahead of the design's one
  task tick;
    repeat (2) @(negedge CLK_IN);
  endtask
  // ****
  // scenarios
  // ****
  task t_trip;
    req_trip[2].l2 = 1'b1;
    tick;
    chk(STAGE_TRIP_OUT, 8'h04);
    chk({ALARM_OUT, TRIP_OUT, STAGE_ALARM_OUT}, 10'h304);
    @(negedge CLK_IN);
    chk(breaker, 1'b1);
    req_trip[5].gnd = 1'b1;
    tick;
    chk({TRIP_PHASE_OUT, ALARM_PHASE_OUT}, 8'h55);
    MASTER_ENABLE_IN = 1'b0;
    tick;
    chk({PROT_ACTIVE_OUT, ALARM_OUT, TRIP_OUT, STAGE_TRIP_OUT}, 11'h000);
    MASTER_ENABLE_IN = 1'b1;
  endtask
  task t_block;
    {EXT_BLOCK_PERMIT_IN, EXT_BLOCK_SOURCE_A_IN, SOURCE_SIGNALS_IN} = {6'h23, 16'h0004};
    tick;
    chk({PROT_ACTIVE_OUT, PROT_EXT_BLOCKED_OUT, TRIP_OUT}, 3'b010);
    {EXT_BLOCK_SOURCE_B_IN, SOURCE_SIGNALS_IN} = {5'h10, 16'h8000};
    tick;
    chk({PROT_ACTIVE_OUT, PROT_EXT_BLOCKED_OUT}, 2'b01);
    SOURCE_SIGNALS_IN = 16'h0000;
    tick;
    chk({PROT_ACTIVE_OUT, PROT_EXT_BLOCKED_OUT, TRIP_OUT}, 3'b101);
    {EXT_BLOCK_PERMIT_IN, SOURCE_SIGNALS_IN} = {1'b0, 16'hFFFF};
    tick;
    chk(PROT_ACTIVE_OUT, 1'b1);
    {EXT_BLOCK_PERMIT_IN, EXT_BLOCK_SOURCE_A_IN, EXT_BLOCK_SOURCE_B_IN} = {1'b1, 10'h000};
    tick;
    chk(PROT_ACTIVE_OUT, 1'b1);
    {EXT_BLOCK_PERMIT_IN, SOURCE_SIGNALS_IN} = {1'b0, 16'h0003};
  endtask
  task t_gate;
    TRIP_PERM_BLOCK_IN = 8'h04;
    tick;
    chk({STAGE_TRIP_OUT, STAGE_ALARM_OUT}, 16'h2024);
    {TRIP_PERM_BLOCK_IN, EXT_TRIP_BLOCK_SOURCE_IN[25+:5]} = {8'h00, 5'h01};
    tick;
    chk(STAGE_TRIP_OUT, 8'h24);
    EXT_TRIP_BLOCK_PERMIT_IN = 8'h20;
    tick;
    chk({STAGE_TRIP_OUT, STAGE_TRIP_BLOCKED_OUT}, 16'h0420);
    MODULE_ENABLE_IN = 4'hD;
    tick;
    chk(STAGE_ALARM_OUT, 8'h04);
    {MODULE_BLOCK_PERMIT_IN, MODULE_BLOCK_SOURCE_IN[10+:5]} = {4'h4, 5'h02};
    tick;
    chk({STAGE_ALARM_OUT, TRIP_OUT}, 9'h000);
    {MODULE_BLOCK_PERMIT_IN, MODULE_ENABLE_IN, req_trip} = {8'h0F, 32'h0};
    {req_alarm[0].l1, req_alarm[7].l3} = 2'b11;
    tick;
    chk({ALARM_PHASE_OUT, TRIP_PHASE_OUT, STAGE_ALARM_OUT, TRIP_OUT}, 17'h14102);
  endtask
  task t_misc;
    VOLTS_IN = {16'h00A3, 16'h00A4, 16'h1234, 16'h00A3, 16'h00A4, 16'h0001, 16'h7FFF, 16'h0};
    tick;
    chk(DISPLAY_VOLTS_OUT, {32'h00A4, 16'h1234, 32'h00A4, 32'h7FFF, 16'h0});
    chk(RECORD_VOLTS_OUT, VOLTS_IN);
    repeat (3) begin
      {STAGE_FAULT_EVENT_IN, GRID_FAULT_EVENT_IN} = 2'b11;
      @(negedge CLK_IN);
      {STAGE_FAULT_EVENT_IN, GRID_FAULT_EVENT_IN} = 2'b00;
      @(negedge CLK_IN);
    end
    chk({FAULT_NUMBER_OUT, GRID_FAULT_COUNT_OUT}, 32'h00030003);
    {RESET_COUNTERS_IN, STAGE_FAULT_EVENT_IN} = 2'b11;
    tick;
    chk({FAULT_NUMBER_OUT, GRID_FAULT_COUNT_OUT}, 32'h0);
  endtask
  initial begin
    {EXT_BLOCK_PERMIT_IN, STAGE_FAULT_EVENT_IN, GRID_FAULT_EVENT_IN, RESET_COUNTERS_IN} = '0;
    {EXT_BLOCK_SOURCE_A_IN, EXT_BLOCK_SOURCE_B_IN, SOURCE_SIGNALS_IN, VOLTS_IN} = '0;
    {MODULE_BLOCK_PERMIT_IN, MODULE_BLOCK_SOURCE_IN, TRIP_PERM_BLOCK_IN} = '0;
    {EXT_TRIP_BLOCK_PERMIT_IN, EXT_TRIP_BLOCK_SOURCE_IN, req_alarm, req_trip} = '0;
    {MASTER_ENABLE_IN, MODULE_ENABLE_IN, STAGE_MODULE_IN} = {5'h1F, 16'hE4E4};
    PHASE_ZERO_THRESHOLD_IN = 16'h00A4;
    RESID_MEAS_ZERO_THRESHOLD_IN = 16'h00A4;
    RESID_CALC_ZERO_THRESHOLD_IN = 16'h00A4;
    SYMCOMP_ZERO_THRESHOLD_IN = 16'h00A4;
    repeat (5) @(negedge CLK_IN);
    RESET_N_IN = 1'b1;
    t_trip;
    t_block;
    t_gate;
    t_misc;
    finish_test;
  end
  // whole run needs well under 200 cycles
  initial begin
    repeat (2000) @(posedge CLK_IN);
    error_cnt++;
    finish_test;
  end
endmodule
